/* rtl/nvacc_pkg.sv */
// Constants, types and timing for the non-volatile byte store access unit
// Overview of operation
// RULE1: Provide a 32 by 8 bit non-volatile store outside the data space.
// RULE2: Each store read or write moves one byte via address and data.
// RULE3: Control register is sector 1 location 40H, reached by pointer only.
// RULE4: Address and data registers sit in sector 0, directly accessible.
// RULE5: Address holds 5-bit index, reset zero, bits 7 to 5 read zero.
// RULE6: Data register is full 8-bit read/write, reset to zero.
// RULE7: Control bit 3 guards writes; while zero no write may start.
// RULE8: Setting control bit 2 starts a write; held high until it ends.
// RULE9: Write start with program guard clear has no effect.
// RULE10: Setting control bit 0 starts a read; cleared when read ends.
// RULE11: Control bit 1 guards reads; while zero no read may start.
// RULE12: Fetched byte appears in data register and stays until next access.
// RULE13: Each finished write raises the write-complete request flag.
// RULE14: Software sets guard and start in separate control writes.
package nvacc_pkg;

    // Store geometry
    localparam int NVACC_DEPTH = 32;
    localparam int NVACC_AW = 5;
    localparam int NVACC_DW = 8;

    // Sector selects and register locations
    localparam logic [7:0] NVACC_SECTOR0 = 8'h00;
    localparam logic [7:0] NVACC_SECTOR1 = 8'h01;
    localparam logic [7:0] NVACC_CTL_OFS = 8'h40;
    localparam logic [7:0] NVACC_ADDR_OFS = 8'h1E;
    localparam logic [7:0] NVACC_DATA_OFS = 8'h1F;

    // Control register field positions
    localparam int NVACC_READ_BIT = 0;
    localparam int NVACC_FETCH_UNLOCK_BIT = 1;
    localparam int NVACC_WRITE_BIT = 2;
    localparam int NVACC_PROG_UNLOCK_BIT = 3;

    // Reset values
    localparam logic [7:0] NVACC_CTL_RST = 8'h00;
    localparam logic [7:0] NVACC_ADDR_RST = 8'h00;
    localparam logic [7:0] NVACC_DATA_RST = 8'h00;

    // Timing: write time is rounded up to whole clock cycles
    localparam int NVACC_CLK_PERIOD_PS = 5000;
    localparam int NVACC_WRITE_TIME_NS = 2000;
    localparam int NVACC_WRITE_CYCLES =
        (NVACC_WRITE_TIME_NS * 1000 + NVACC_CLK_PERIOD_PS - 1) /
        NVACC_CLK_PERIOD_PS;
    localparam int NVACC_READ_CYCLES = 2;
    localparam int NVACC_CNT_W = 16;

    typedef enum logic [1:0] {
        NVACC_IDLE,
        NVACC_READ,
        NVACC_WRITE
    } nvacc_state_e;

endpackage

/* rtl/nvacc_store.sv */
// Byte-wide non-volatile store array with registered read port
`timescale 1ns/1ps
module nvacc_store #(
    parameter int DEPTH = nvacc_pkg::NVACC_DEPTH,
    parameter int AW = nvacc_pkg::NVACC_AW,
    parameter int DW = nvacc_pkg::NVACC_DW
) (
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic [AW-1:0] addr_i,
    input wire logic [DW-1:0] wdata_i,
    input wire logic we_i,
    input wire logic re_i,
    output logic [DW-1:0] rdata_o
);
    import nvacc_pkg::*;

    typedef struct packed {
        logic [DW-1:0] rdata;
    } nvacc_store_s;

    nvacc_store_s q, d;
    // Array is not reset: its contents model retained data
    logic [DW-1:0] mem [DEPTH]; // RULE1

    initial begin
        if (DEPTH > (1 << AW) || DEPTH < 1) begin
            $error("nvacc_store: depth does not fit address width");
        end
    end

    // Array write, one byte per cycle
    always_ff @(posedge sys_clk_i) begin
        if (we_i) begin
            mem[addr_i] <= wdata_i; // RULE2
        end
    end

    // Read capture; a write in the same cycle wins, the read is dropped and rdata keeps its last value
    always_comb begin
        d = q;
        if (re_i && !we_i) begin
            d.rdata = mem[addr_i]; // RULE2
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign rdata_o = q.rdata;

    AST_ONE_BYTE_OP: assert property (@(posedge sys_clk_i) // RULE2
        disable iff (!resetn_i) !(we_i && re_i))
        else $error("Store read and write in one cycle");
endmodule

/* rtl/nvacc_top.sv */
// Access unit: address, data and control registers plus cycle sequencer
`timescale 1ns/1ps
module nvacc_top #(
    parameter int DEPTH = nvacc_pkg::NVACC_DEPTH,
    parameter int AW = nvacc_pkg::NVACC_AW,
    parameter int WRITE_CYCLES = nvacc_pkg::NVACC_WRITE_CYCLES,
    parameter int READ_CYCLES = nvacc_pkg::NVACC_READ_CYCLES
) (
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic [7:0] bus_sector_i,
    input wire logic [7:0] bus_addr_i,
    input wire logic bus_wr_i,
    input wire logic bus_rd_i,
    input wire logic [7:0] bus_wdata_i,
    output logic [7:0] bus_rdata_o,
    output logic nv_busy_o,
    output logic nv_done_flag_o
);
    import nvacc_pkg::*;

    localparam int AST_WR_MAX = 1000;
    localparam int AST_RD_MAX = 16;

    typedef struct packed {
        nvacc_state_e state;
        logic [NVACC_CNT_W-1:0] cnt;
        logic [AW-1:0] nv_address;
        logic [7:0] nv_data;
        logic nv_program_unlock;
        logic write_start;
        logic nv_fetch_unlock;
        logic read_start;
        logic [7:0] rdata;
        logic busy;
        logic done;
        logic [AW-1:0] st_addr;
        logic [7:0] st_wdata;
        logic st_we;
        logic st_re;
    } nvacc_top_s;

    nvacc_top_s q, d;
    logic [7:0] st_rdata;
    logic [7:0] ctl_view;
    logic [7:0] addr_view;
    logic sel_addr;
    logic sel_data;
    logic sel_ctl;

    // Cycle counts are bounded by the counter and by the timing checks
    initial begin
        if (WRITE_CYCLES < 2 || WRITE_CYCLES > AST_WR_MAX) begin
            $error("nvacc_top: write cycle count out of range");
        end
        if (READ_CYCLES < 2 || READ_CYCLES > AST_RD_MAX) begin
            $error("nvacc_top: read cycle count out of range");
        end
        if (AW > 8 || DEPTH > (1 << AW)) begin
            $error("nvacc_top: address width does not fit register");
        end
    end

    // Register decode on sector and location
    function automatic logic reg_hit(input logic [7:0] sector,
                                     input logic [7:0] addr,
                                     input logic [7:0] want_sector,
                                     input logic [7:0] want_addr);
        reg_hit = (sector == want_sector) && (addr == want_addr);
    endfunction

    // Control reaches only through sector 1; address and data in sector 0
    assign sel_ctl = reg_hit(bus_sector_i, bus_addr_i,
                             NVACC_SECTOR1, NVACC_CTL_OFS); // RULE3
    assign sel_addr = reg_hit(bus_sector_i, bus_addr_i,
                              NVACC_SECTOR0, NVACC_ADDR_OFS); // RULE4
    assign sel_data = reg_hit(bus_sector_i, bus_addr_i,
                              NVACC_SECTOR0, NVACC_DATA_OFS); // RULE4

    // Store array
    nvacc_store #(
        .DEPTH(DEPTH),
        .AW(AW),
        .DW(8)
    ) u_store (
        .sys_clk_i(sys_clk_i),
        .resetn_i(resetn_i),
        .addr_i(q.st_addr),
        .wdata_i(q.st_wdata),
        .we_i(q.st_we),
        .re_i(q.st_re),
        .rdata_o(st_rdata)
    );

    // Next state: register access, launch decisions and cycle timing
    always_comb begin
        d = q;
        ctl_view = '0;
        addr_view = '0;
        d.done = 1'b0;
        d.st_we = 1'b0;
        d.st_re = 1'b0;

        // Read views; unimplemented bits read as zero
        ctl_view[NVACC_PROG_UNLOCK_BIT] = q.nv_program_unlock;
        ctl_view[NVACC_WRITE_BIT] = q.write_start;
        ctl_view[NVACC_FETCH_UNLOCK_BIT] = q.nv_fetch_unlock;
        ctl_view[NVACC_READ_BIT] = q.read_start;
        addr_view[AW-1:0] = q.nv_address; // RULE5

        // Bus read answer, registered; unmapped locations read zero
        if (bus_rd_i) begin
            if (sel_ctl) begin
                d.rdata = ctl_view;
            end else if (sel_addr) begin
                d.rdata = addr_view;
            end else if (sel_data) begin
                d.rdata = q.nv_data;
            end else begin
                d.rdata = '0;
            end
        end

        // Direct register writes
        if (bus_wr_i && sel_addr) begin
            d.nv_address = bus_wdata_i[AW-1:0]; // RULE5
        end
        if (bus_wr_i && sel_data) begin
            d.nv_data = bus_wdata_i; // RULE6
        end

        // Control write; starts look at the guard as it stood before
        // this write, so setting guard and start together starts nothing
        if (bus_wr_i && sel_ctl) begin
            d.nv_program_unlock = bus_wdata_i[NVACC_PROG_UNLOCK_BIT];
            d.nv_fetch_unlock = bus_wdata_i[NVACC_FETCH_UNLOCK_BIT];
            if (q.state == NVACC_IDLE) begin
                if (bus_wdata_i[NVACC_WRITE_BIT] &&
                    q.nv_program_unlock) begin // RULE7 RULE9 RULE14
                    d.write_start = 1'b1; // RULE8
                    d.state = NVACC_WRITE;
                    d.busy = 1'b1;
                    d.cnt = NVACC_CNT_W'(WRITE_CYCLES - 1);
                    d.st_addr = q.nv_address; // RULE2
                    d.st_wdata = q.nv_data;
                end else if (bus_wdata_i[NVACC_READ_BIT] &&
                             q.nv_fetch_unlock) begin // RULE11 RULE14
                    d.read_start = 1'b1; // RULE10
                    d.state = NVACC_READ;
                    d.busy = 1'b1;
                    d.cnt = NVACC_CNT_W'(READ_CYCLES - 1);
                    d.st_addr = q.nv_address; // RULE2
                    d.st_re = 1'b1;
                end
            end
        end

        // Cycle sequencer; start bits are held by hardware while busy
        case (q.state)
            NVACC_IDLE: begin
            end
            NVACC_READ: begin
                if (q.cnt == '0) begin
                    d.nv_data = st_rdata; // RULE12
                    d.read_start = 1'b0; // RULE10
                    d.busy = 1'b0;
                    d.state = NVACC_IDLE;
                end else begin
                    d.cnt = q.cnt - NVACC_CNT_W'(1);
                end
            end
            NVACC_WRITE: begin
                if (q.cnt == '0) begin
                    d.write_start = 1'b0; // RULE8
                    d.done = 1'b1; // RULE13
                    d.st_we = 1'b1; // RULE2
                    d.busy = 1'b0;
                    d.state = NVACC_IDLE;
                end else begin
                    d.cnt = q.cnt - NVACC_CNT_W'(1);
                end
            end
            default: begin
                d.state = NVACC_IDLE;
                d.busy = 1'b0;
                d.read_start = 1'b0;
                d.write_start = 1'b0;
            end
        endcase
    end

    // State register; control, address and data clear at reset
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            q <= '0;
            q.state <= NVACC_IDLE;
            q.nv_address <= NVACC_ADDR_RST[AW-1:0]; // RULE5
            q.nv_data <= NVACC_DATA_RST; // RULE6
            q.nv_program_unlock <= NVACC_CTL_RST[NVACC_PROG_UNLOCK_BIT];
            q.nv_fetch_unlock <= NVACC_CTL_RST[NVACC_FETCH_UNLOCK_BIT];
            q.write_start <= NVACC_CTL_RST[NVACC_WRITE_BIT];
            q.read_start <= NVACC_CTL_RST[NVACC_READ_BIT];
        end else begin
            q <= d;
        end
    end

    // Outputs straight from flops
    assign bus_rdata_o = q.rdata;
    assign nv_busy_o = q.busy;
    assign nv_done_flag_o = q.done;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);

    AST_ADDR_HIGH_ZERO: assert property ( // RULE5
        (bus_rd_i && sel_addr) |=> bus_rdata_o[7:AW] == '0)
        else $error("Address register upper bits not zero");

    // Answer shows the control bits as they stood when the read was taken
    AST_CTL_VIEW: assert property ((bus_rd_i && sel_ctl) |=> // RULE3
        bus_rdata_o == {4'h0, $past(q.nv_program_unlock),
        $past(q.write_start), $past(q.nv_fetch_unlock),
        $past(q.read_start)})
        else $error("Control readback mismatch");

    AST_DATA_WRITE: assert property ( // RULE6
        (bus_wr_i && sel_data && q.state != NVACC_READ) |=>
        q.nv_data == $past(bus_wdata_i))
        else $error("Data register did not take written byte");

    AST_ADDR_WRITE: assert property ((bus_wr_i && sel_addr) |=> // RULE4
        q.nv_address == $past(bus_wdata_i[AW-1:0]))
        else $error("Address register did not take written value");

    AST_WRITE_GUARD: assert property ( // RULE9
        $rose(q.write_start) |-> $past(q.nv_program_unlock, 1))
        else $error("Write started without program guard");

    AST_READ_GUARD: assert property ( // RULE11
        $rose(q.read_start) |-> $past(q.nv_fetch_unlock, 1))
        else $error("Read started without fetch guard");

    AST_WRITE_HOLD: assert property ($rose(q.write_start) |-> // RULE8
        q.write_start[*2] ##[0:AST_WR_MAX] $fell(q.write_start))
        else $error("Write start bit not held then cleared");

    AST_READ_END: assert property ($rose(q.read_start) |-> // RULE10
        ##[1:AST_RD_MAX] !q.read_start)
        else $error("Read start bit not cleared in time");

    AST_READ_DATA: assert property ( // RULE12
        $fell(q.read_start) |-> q.nv_data == $past(st_rdata))
        else $error("Fetched byte not in data register");

    AST_DONE_CAUSE: assert property ( // RULE13
        nv_done_flag_o == $fell(q.write_start))
        else $error("Write complete flag not tied to write end");

    AST_STORE_WE: assert property ( // RULE2
        nv_done_flag_o |-> q.st_we && !q.busy)
        else $error("Write end without store write");

    // Launch and refusal, seen one edge after the control write
    AST_WRITE_LAUNCH: assert property ((bus_wr_i && sel_ctl && // RULE8
        bus_wdata_i[NVACC_WRITE_BIT] && q.nv_program_unlock &&
        q.state == NVACC_IDLE) |=> q.write_start && nv_busy_o)
        else $error("Guarded write start did not launch");

    AST_WRITE_REFUSED: assert property ((bus_wr_i && sel_ctl && // RULE7
        !q.nv_program_unlock && q.state == NVACC_IDLE) |=>
        !q.write_start)
        else $error("Write launched without program guard");

    AST_READ_LAUNCH: assert property ((bus_wr_i && sel_ctl && // RULE10
        bus_wdata_i[NVACC_READ_BIT] && q.nv_fetch_unlock &&
        !(bus_wdata_i[NVACC_WRITE_BIT] && q.nv_program_unlock) &&
        q.state == NVACC_IDLE) |=> q.read_start && nv_busy_o)
        else $error("Guarded read start did not launch");

    AST_READ_REFUSED: assert property ((bus_wr_i && sel_ctl && // RULE11
        !q.nv_fetch_unlock && q.state == NVACC_IDLE) |=> !q.read_start)
        else $error("Read launched without fetch guard");

    AST_ONE_CYCLE: assert property ( // RULE2
        !(q.write_start && q.read_start))
        else $error("Read and write cycles overlap");

    AST_BUSY_LEVEL: assert property ( // RULE8
        nv_busy_o == (q.write_start || q.read_start))
        else $error("Busy does not match running cycle");

    // Stored byte only changes by a direct write or a finished read
    AST_DATA_HOLD: assert property ( // RULE12
        (!(bus_wr_i && sel_data) && q.state != NVACC_READ) |=>
        $stable(q.nv_data))
        else $error("Data register changed with no access");

    AST_ADDR_HOLD: assert property (!(bus_wr_i && sel_addr) |=> // RULE5
        $stable(q.nv_address))
        else $error("Address register changed with no write");

    COV_WRITE_DONE: cover property (nv_done_flag_o);
    COV_READ_DONE: cover property ($fell(q.read_start));
    COV_WRITE_REFUSED: cover property (bus_wr_i && sel_ctl &&
        bus_wdata_i[NVACC_WRITE_BIT] && !q.nv_program_unlock &&
        q.state == NVACC_IDLE);
    COV_READ_REFUSED: cover property (bus_wr_i && sel_ctl &&
        bus_wdata_i[NVACC_READ_BIT] && !q.nv_fetch_unlock &&
        q.state == NVACC_IDLE);
    COV_BOTH_STARTS: cover property (bus_wr_i && sel_ctl &&
        bus_wdata_i[NVACC_WRITE_BIT] && bus_wdata_i[NVACC_READ_BIT] &&
        q.nv_program_unlock && q.nv_fetch_unlock);
endmodule

/* tb/test_byte_nv_memory_access.sv */
// Self-checking bench for the non-volatile byte store access unit
`timescale 1ns/1ps
module test_byte_nv_memory_access;
    import nvacc_pkg::*;
    localparam int WC = 3;
    localparam int RC = 2;
    logic sys_clk;
    logic resetn;
    logic [7:0] bus_sector;
    logic [7:0] bus_addr;
    logic bus_wr;
    logic bus_rd;
    logic [7:0] bus_wdata;
    logic [7:0] bus_rdata;
    logic nv_busy;
    logic nv_done_flag;
    int mismatches = 0;
    int checks = 0;
    int cycles = 0;
    int busy_cnt = 0;
    int done_cnt = 0;

    nvacc_top #(.WRITE_CYCLES(WC), .READ_CYCLES(RC)) i_dut (
        .sys_clk_i(sys_clk), .resetn_i(resetn), .bus_sector_i(bus_sector),
        .bus_addr_i(bus_addr), .bus_wr_i(bus_wr), .bus_rd_i(bus_rd),
        .bus_wdata_i(bus_wdata), .bus_rdata_o(bus_rdata),
        .nv_busy_o(nv_busy), .nv_done_flag_o(nv_done_flag));

    // Clock at 200 MHz
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // Count busy cycles, done pulses and run length for timeout
    always @(posedge sys_clk) begin
        cycles++;
        if (nv_busy === 1'b1) busy_cnt++;
        if (nv_done_flag === 1'b1) done_cnt++;
        if (cycles == 20000) begin
            mismatches++;
            $display("unexpected at %0t: run timed out", $time);
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("mismatches %0d checks %0d", mismatches, checks);
        if (mismatches == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                       input string what);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: %s got %h exp %h", $time, what,
                     got, exp);
        end
    endtask

    // One write strobe; an idle edge follows so strobes never collide
    task automatic bus_write(input logic [7:0] s, input logic [7:0] a,
                             input logic [7:0] d);
        bus_sector <= s;
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge sys_clk);
        bus_wr <= 1'b0;
        @(posedge sys_clk);
    endtask

    // Answer is sampled mid-cycle, well after it has settled
    task automatic bus_read(input logic [7:0] s, input logic [7:0] a,
                            output logic [7:0] d);
        bus_sector <= s;
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge sys_clk);
        bus_rd <= 1'b0;
        @(posedge sys_clk);
        @(negedge sys_clk);
        d = bus_rdata;
        @(posedge sys_clk);
    endtask

    task automatic rd_chk(input logic [7:0] s, input logic [7:0] a,
                          input logic [7:0] exp, input string what);
        logic [7:0] d;
        bus_read(s, a, d);
        chk(d, exp, what);
    endtask

    // Bounded wait for the cycle to end
    task automatic wait_idle();
        int n;
        n = 0;
        @(negedge sys_clk);
        while (nv_busy !== 1'b0 && n < 1000) begin
            @(negedge sys_clk);
            n++;
        end
        if (n >= 1000) begin
            mismatches++;
            $display("unexpected at %0t: busy never dropped", $time);
        end
        @(posedge sys_clk);
    endtask

    task automatic ctl_wr(input logic [7:0] d);
        bus_write(NVACC_SECTOR1, NVACC_CTL_OFS, d);
    endtask

    // Guarded write of one byte, with busy length and done pulse checked
    task automatic store_write(input logic [7:0] a, input logic [7:0] d);
        int b0;
        int d0;
        bus_write(NVACC_SECTOR0, NVACC_ADDR_OFS, a);
        bus_write(NVACC_SECTOR0, NVACC_DATA_OFS, d);
        ctl_wr(8'h08);
        b0 = busy_cnt;
        d0 = done_cnt;
        ctl_wr(8'h0C);
        rd_chk(NVACC_SECTOR1, NVACC_CTL_OFS, 8'h0C, "start bit held");
        wait_idle();
        chk(8'(busy_cnt - b0), 8'(WC), "write busy length");
        chk(8'(done_cnt - d0), 8'h01, "done pulses");
        rd_chk(NVACC_SECTOR1, NVACC_CTL_OFS, 8'h08, "start cleared");
    endtask

    // Guarded read of one byte; data register is dirtied first
    task automatic store_read(input logic [7:0] a, input logic [7:0] exp);
        int b0;
        bus_write(NVACC_SECTOR0, NVACC_ADDR_OFS, a);
        bus_write(NVACC_SECTOR0, NVACC_DATA_OFS, ~exp);
        ctl_wr(8'h02);
        b0 = busy_cnt;
        ctl_wr(8'h03);
        wait_idle();
        chk(8'(busy_cnt - b0), 8'(RC), "read busy length");
        rd_chk(NVACC_SECTOR1, NVACC_CTL_OFS, 8'h02, "read cleared");
        rd_chk(NVACC_SECTOR0, NVACC_DATA_OFS, exp, "fetched");
        rd_chk(NVACC_SECTOR0, NVACC_DATA_OFS, exp, "kept");
        ctl_wr(8'h00);
    endtask

    task automatic test_reset_and_regs();
        rd_chk(NVACC_SECTOR0, NVACC_ADDR_OFS, 8'h00, "addr reset");
        rd_chk(NVACC_SECTOR0, NVACC_DATA_OFS, 8'h00, "data reset");
        rd_chk(NVACC_SECTOR1, NVACC_CTL_OFS, 8'h00, "ctl reset");
        bus_write(NVACC_SECTOR0, NVACC_ADDR_OFS, 8'hFF);
        rd_chk(NVACC_SECTOR0, NVACC_ADDR_OFS, 8'h1F, "addr mask");
        bus_write(NVACC_SECTOR0, NVACC_DATA_OFS, 8'hA5);
        rd_chk(NVACC_SECTOR0, NVACC_DATA_OFS, 8'hA5, "data rw");
        ctl_wr(8'hF0);
        rd_chk(NVACC_SECTOR1, NVACC_CTL_OFS, 8'h00, "ctl high bits");
        rd_chk(NVACC_SECTOR1, NVACC_ADDR_OFS, 8'h00, "unmapped");
    endtask

    // Refused starts leave store, flags and busy untouched
    task automatic test_refusals();
        int b0;
        int d0;
        store_write(8'h05, 8'h11);
        ctl_wr(8'h00);
        bus_write(NVACC_SECTOR0, NVACC_DATA_OFS, 8'hEE);
        b0 = busy_cnt;
        d0 = done_cnt;
        ctl_wr(8'h04);
        rd_chk(NVACC_SECTOR1, NVACC_CTL_OFS, 8'h00, "unguarded wr");
        ctl_wr(8'h0C);
        rd_chk(NVACC_SECTOR1, NVACC_CTL_OFS, 8'h08, "same write");
        ctl_wr(8'h00);
        bus_write(NVACC_SECTOR0, NVACC_CTL_OFS, 8'h08);
        bus_write(NVACC_SECTOR0, NVACC_CTL_OFS, 8'h0C);
        ctl_wr(8'h01);
        rd_chk(NVACC_SECTOR1, NVACC_CTL_OFS, 8'h00, "unguarded rd");
        ctl_wr(8'h03);
        rd_chk(NVACC_SECTOR1, NVACC_CTL_OFS, 8'h02, "rd same write");
        repeat (8) @(posedge sys_clk);
        chk(8'(busy_cnt - b0), 8'h00, "no cycle started");
        chk(8'(done_cnt - d0), 8'h00, "no done pulse");
        ctl_wr(8'h00);
        store_read(8'h05, 8'h11);
    endtask

    // Both ends of the 32-byte store, written back to back
    task automatic test_boundaries();
        store_write(8'h00, 8'hC3);
        store_write(8'h1F, 8'h3C);
        store_write(8'h01, 8'h96);
        store_read(8'h00, 8'hC3);
        store_read(8'h1F, 8'h3C);
        store_read(8'h01, 8'h96);
    endtask

    // Both starts behind both guards: the write wins, the read is dropped
    task automatic test_contention();
        bus_write(NVACC_SECTOR0, NVACC_ADDR_OFS, 8'h07);
        bus_write(NVACC_SECTOR0, NVACC_DATA_OFS, 8'h5A);
        ctl_wr(8'h0A);
        ctl_wr(8'h0F);
        rd_chk(NVACC_SECTOR1, NVACC_CTL_OFS, 8'h0E, "write wins");
        wait_idle();
        rd_chk(NVACC_SECTOR1, NVACC_CTL_OFS, 8'h0A, "both ended");
        ctl_wr(8'h00);
        store_read(8'h07, 8'h5A);
    endtask

    // Reset in mid-write clears the registers and drops the write
    task automatic test_mid_reset();
        int d0;
        store_write(8'h09, 8'h77);
        bus_write(NVACC_SECTOR0, NVACC_DATA_OFS, 8'h44);
        ctl_wr(8'h08);
        d0 = done_cnt;
        ctl_wr(8'h0C);
        resetn <= 1'b0;
        repeat (4) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
        chk({7'h00, nv_busy}, 8'h00, "busy cleared");
        rd_chk(NVACC_SECTOR1, NVACC_CTL_OFS, 8'h00, "ctl cleared");
        rd_chk(NVACC_SECTOR0, NVACC_ADDR_OFS, 8'h00, "addr cleared");
        rd_chk(NVACC_SECTOR0, NVACC_DATA_OFS, 8'h00, "data cleared");
        chk(8'(done_cnt - d0), 8'h00, "no done after reset");
        store_read(8'h09, 8'h77);
    endtask

    initial begin
        resetn <= 1'b0;
        bus_sector <= 8'h00;
        bus_addr <= 8'h00;
        bus_wr <= 1'b0;
        bus_rd <= 1'b0;
        bus_wdata <= 8'h00;
        repeat (12) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
        test_reset_and_regs();
        test_refusals();
        test_boundaries();
        test_contention();
        test_mid_reset();
        wrap_up();
    end
endmodule
